//--- common/reset_cause_map.vh
// Register offsets, field positions and reset values for the reset cause block.
// Included by bare name from the status unit design file; holds definitions only.
`ifndef RESET_CAUSE_MAP_VH
`define RESET_CAUSE_MAP_VH

`define RCS_ADDR_STATUS 4'h0
`define RCS_ADDR_SOURCES 4'h4
`define RCS_BIT_TRAP 15
`define RCS_BIT_ILLEGAL 14
`define RCS_BIT_CFGMIS 9
`define RCS_BIT_PROGMEM_SLEEP_POWER 8
`define RCS_BIT_EXT 7
`define RCS_BIT_SWR 6
`define RCS_BIT_WDTEN 5
`define RCS_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define RCS_BIT_SLEEP 3
`define RCS_BIT_IDLE 2
`define RCS_BIT_BOR 1
`define RCS_BIT_POR 0
`define RCS_POR_VALUE 16'h0003
`define RCS_IMPL_MASK 16'hc3ff
`define RCS_NUM_SOURCES 9
`define RCS_SRC_POR 0
`define RCS_SRC_EXT 1
`define RCS_SRC_SWR 2
`define RCS_SRC_WDT 3
`define RCS_SRC_BOR 4
`define RCS_SRC_CFG 5
`define RCS_SRC_TRAP 6
`define RCS_SRC_ILL 7
`define RCS_SRC_UWR 8

`endif

//--- hw/reset_merge.v
// Merges the individual reset requests into one master reset level.
// Assumes every request is a level synchronous to hclk.
`timescale 1ns/10ps
module reset_merge #(
  parameter N = 9
) (
  // Sources
  input wire [N-1:0] source_active,
  // Merged result
  output wire master_reset_signal
);

  assign master_reset_signal = |source_active;

endmodule

//--- hw/reset_cause_status_unit.v
// Reset cause status block: merges reset sources, records causes, AHB-Lite slave.
// Assumes a single AHB-Lite master with hready equal to this slave's hreadyout;
// hresetn is the power-on root reset, all other sources are synchronous levels.
`timescale 1ns/10ps
`include "reset_cause_map.vh"
module reset_cause_status_unit #(
  parameter NSRC = 9
) (
  // Clock and power-on root reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Reset sources other than power-on
  input wire external_pin_reset,
  input wire software_reset_req,
  input wire watchdog_timeout,
  input wire brownout_reset,
  input wire config_mismatch_reset,
  input wire trap_conflict_reset,
  input wire illegal_opcode_reset,
  input wire illegal_address_mode_reset,
  input wire uninit_wreg_reset,
  // Instruction events from the CPU
  input wire power_save_sleep,
  input wire power_save_idle,
  input wire watchdog_clear_instruction,
  // Configuration fuse
  input wire watchdog_fuse_enable,
  // Results
  output wire master_reset_signal,
  output reg watchdog_enabled,
  output reg progmem_bias_on_in_sleep,
  output reg regulator_standby_in_sleep
);

  reg [15:0] reset_cause_status;
  reg [15:0] next_status;
  reg [NSRC-1:0] sources;
  reg por_pending;
  reg wr_pending;
  reg [3:0] wr_addr;
  wire [NSRC-1:0] source_vec;
  wire illegal_any;
  wire access;

  // Power-on is held as a pending level that lasts one cycle after release,
  // so that the merged reset covers the first edge the logic sees.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_pending <= 1'b1;
    end else begin
      por_pending <= 1'b0;
    end
  end

  assign source_vec = {uninit_wreg_reset, illegal_opcode_reset | illegal_address_mode_reset,
                       trap_conflict_reset, config_mismatch_reset, brownout_reset,
                       watchdog_timeout, software_reset_req, external_pin_reset, por_pending};

  // The source vector is registered so the sources word read-back can show it.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sources <= {NSRC{1'b0}};
    end else begin
      sources <= source_vec;
    end
  end

  reset_merge #(
    .N(NSRC)
  ) u_merge (
    .source_active(source_vec),
    .master_reset_signal(master_reset_signal)
  );

  assign illegal_any = illegal_opcode_reset | illegal_address_mode_reset | uninit_wreg_reset;

  // AHB-Lite: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign access = hsel & htrans[1] & hready;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 4'h0;
    end else begin
      wr_pending <= access & hwrite;
      wr_addr <= haddr[3:0];
    end
  end

  // Software write is applied first, then hardware events, so a set from
  // hardware in the same cycle as a software clear is never lost.
  always @* begin
    next_status = reset_cause_status;
    if (wr_pending && wr_addr == `RCS_ADDR_STATUS) begin
      next_status = hwdata[15:0] & `RCS_IMPL_MASK;
    end
    if (watchdog_clear_instruction || power_save_sleep || power_save_idle) begin
      next_status[`RCS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    end
    if (trap_conflict_reset) begin
      next_status[`RCS_BIT_TRAP] = 1'b1;
    end
    if (illegal_any) begin
      next_status[`RCS_BIT_ILLEGAL] = 1'b1;
    end
    if (config_mismatch_reset) begin
      next_status[`RCS_BIT_CFGMIS] = 1'b1;
    end
    if (external_pin_reset) begin
      next_status[`RCS_BIT_EXT] = 1'b1;
    end
    if (software_reset_req) begin
      next_status[`RCS_BIT_SWR] = 1'b1;
    end
    if (watchdog_timeout) begin
      next_status[`RCS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    end
    if (power_save_sleep) begin
      next_status[`RCS_BIT_SLEEP] = 1'b1;
    end
    if (power_save_idle) begin
      next_status[`RCS_BIT_IDLE] = 1'b1;
    end
    if (brownout_reset) begin
      next_status[`RCS_BIT_BOR] = 1'b1;
    end
  end

  // Only hresetn (power-on) forces the status word; other resets merely add flags.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_cause_status <= `RCS_POR_VALUE;
    end else begin
      reset_cause_status <= next_status;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_enabled <= 1'b0;
      progmem_bias_on_in_sleep <= 1'b0;
      regulator_standby_in_sleep <= 1'b1;
    end else begin
      watchdog_enabled <= watchdog_fuse_enable | next_status[`RCS_BIT_WDTEN];
      progmem_bias_on_in_sleep <= next_status[`RCS_BIT_PROGMEM_SLEEP_POWER];
      regulator_standby_in_sleep <= ~next_status[`RCS_BIT_PROGMEM_SLEEP_POWER];
    end
  end

  // Read data registered in the address phase; only haddr[3:0] is decoded, so higher words alias and unmapped offsets read zero.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (access && !hwrite) begin
      case (haddr[3:0])
        `RCS_ADDR_STATUS: hrdata <= {16'h0000, next_status};
        `RCS_ADDR_SOURCES: hrdata <= {{(32-NSRC){1'b0}}, sources};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule

//--- verification/reset_cause_props.sv
// Port assertions for the reset cause block.
// Bound to reset_cause_status_unit; hresetn is the power-on root.
`timescale 1ns/10ps
module reset_cause_props (
  input wire hclk, hresetn, hsel, hwrite, hready,
  input wire [1:0] htrans,
  input wire [31:0] haddr, hrdata,
  input wire external_pin_reset, software_reset_req, watchdog_timeout, brownout_reset,
  input wire config_mismatch_reset, trap_conflict_reset, illegal_opcode_reset,
  input wire illegal_address_mode_reset, uninit_wreg_reset, master_reset_signal,
  input wire watchdog_fuse_enable, watchdog_enabled, progmem_bias_on_in_sleep, regulator_standby_in_sleep
);
  wire ill = illegal_opcode_reset | illegal_address_mode_reset | uninit_wreg_reset;
  wire any_src = ill | external_pin_reset | software_reset_req | watchdog_timeout | brownout_reset
    | config_mismatch_reset | trap_conflict_reset;
  wire rd0 = hsel & htrans[1] & hready & !hwrite & (haddr == 32'h0);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_merge_any: assert property (any_src |-> master_reset_signal) else $error("merge");
  // A mid-run power-on pulse leaves the pending power-on source high for one edge after release.
  a_no_spurious: assert property (hresetn && $past(hresetn) && !any_src |-> !master_reset_signal)
    else $error("spurious");
  a_trap_flag: assert property (rd0 && trap_conflict_reset |=> hrdata[15]) else $error("trap");
  a_illegal_flag: assert property (rd0 && ill |=> hrdata[14]) else $error("illegal");
  a_pin_flag: assert property (rd0 && external_pin_reset |=> hrdata[7]) else $error("pin");
  a_gap_zero: assert property (rd0 |=> hrdata[13:10] == 4'h0) else $error("gap");
  a_fuse_on: assert property (hresetn && watchdog_fuse_enable |=> watchdog_enabled) else $error("fuse");
  a_bias_pair: assert property (progmem_bias_on_in_sleep != regulator_standby_in_sleep) else $error("bias");
endmodule
bind reset_cause_status_unit reset_cause_props u_props (.*);

//--- verification/reset_source_model.sv
// Reset sources: holds the chosen source high while fire is set.
// Assumes fire and kind change just after hclk rises.
`timescale 1ns/10ps
module reset_source_model (
  input wire hclk,
  input wire fire,
  input wire [3:0] kind,
  output reg [8:0] src
);
  initial src = 9'h000;
  always @(posedge hclk) src <= fire ? 9'h001 << kind : 9'h000;
endmodule

//--- verification/reset_cause_status_unit_bench.sv
// Self-checking bench for the reset cause block.
// Inputs change by non-blocking assignment after hclk rises.
`timescale 1ns/10ps
module reset_cause_status_unit_bench;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fuse = 0, fire = 0;
  reg [1:0] htrans = 0;
  reg [2:0] ev = 0;
  reg [3:0] kind = 0;
  reg [31:0] haddr = 0, hwdata = 0, e;
  wire hreadyout, hresp, mrst, wden, bias, stby;
  wire [8:0] s;
  wire [31:0] hrdata;
  integer n_mismatch = 0, n_tests = 0, cyc = 0, i;
  // Flag bit of each source, first source in the lowest digit.
  localparam [35:0] fbit = 36'heeef91467;
  always #10 hclk = ~hclk;
  reset_source_model u_src (.hclk(hclk), .fire(fire), .kind(kind), .src(s));
  reset_cause_status_unit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_pin_reset(s[0]), .software_reset_req(s[1]),
    .watchdog_timeout(s[2]), .brownout_reset(s[3]), .config_mismatch_reset(s[4]),
    .trap_conflict_reset(s[5]), .illegal_opcode_reset(s[6]), .illegal_address_mode_reset(s[7]),
    .uninit_wreg_reset(s[8]), .power_save_sleep(ev[0]), .power_save_idle(ev[1]),
    .watchdog_clear_instruction(ev[2]), .watchdog_fuse_enable(fuse), .master_reset_signal(mrst),
    .watchdog_enabled(wden), .progmem_bias_on_in_sleep(bias), .regulator_standby_in_sleep(stby));
  task chk(input [31:0] seen, input [31:0] want);
    begin
      n_tests = n_tests + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: %h, expected %h", $time, seen, want);
      end
    end
  endtask
  // Read data is compared only for reads.
  task xfer(input w, input [31:0] a, input [31:0] d, input [31:0] want);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      if (!w) chk(hrdata, want);
      chk({31'h0, hresp}, 32'h0);
    end
  endtask
  task t_por;
    begin
      xfer(0, 0, 0, 32'h3);
      xfer(1, 0, 0, 0);
      xfer(0, 0, 0, 0);
      e = 0;
    end
  endtask
  task t_sources;
    for (i = 0; i < 9; i = i + 1) begin
      @(posedge hclk);
      kind <= i[3:0];
      fire <= 1'b1;
      e[fbit[i*4 +: 4]] = 1'b1;
      xfer(0, 0, 0, e);
      chk({31'h0, mrst}, 32'h1);
      // Opcode and addressing-mode requests share one bit of the raw source word.
      xfer(0, 32'h4, 0, 32'h1 << (i + 1 - (i >= 7)));
      fire <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({31'h0, mrst}, 32'h0);
    end
  endtask
  task t_events;
    for (i = 2; i >= 0; i = i - 1) begin
      @(posedge hclk);
      ev[i] <= 1'b1;
      @(posedge hclk);
      ev <= 3'h0;
      e = i == 2 ? e & 32'hffef : e | (32'h1 << (3 - i));
      xfer(0, 0, 0, e);
    end
  endtask
  task t_regs;
    begin
      xfer(1, 0, 32'hffffffff, 0);
      xfer(0, 0, 0, 32'hc3ff);
      chk({31'h0, mrst}, 32'h0);
      xfer(1, 0, 32'h120, 0);
      repeat (2) @(posedge hclk);
      chk({29'h0, wden, bias, stby}, 32'h6);
      xfer(1, 0, 0, 0);
      fuse <= 1'b1;
      repeat (2) @(posedge hclk);
      chk({29'h0, wden, bias, stby}, 32'h5);
      xfer(1, 0, 32'hc3ff, 0);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      xfer(0, 0, 0, 32'h3);
    end
  endtask
  task report_and_stop;
    begin
      $display("mismatches %0d of %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_por;
    t_sources;
    t_events;
    t_regs;
    report_and_stop;
  end
endmodule
